// ===== design/awdt_regs.svh
`ifndef AWDT_REGS_SVH
`define AWDT_REGS_SVH

// ------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ------------------------------------------------------------
`define AWDT_IDX_CH5_HYST 10'h034
`define AWDT_IDX_CH5_UPPER 10'h035
`define AWDT_IDX_CH5_LOWER_NIB 10'h036
`define AWDT_IDX_CH5_LOWER 10'h037
`define AWDT_IDX_CH6_HYST 10'h038
`define AWDT_IDX_CH6_UPPER 10'h039
`define AWDT_IDX_CH6_LOWER_NIB 10'h03a
`define AWDT_IDX_CH6_LOWER 10'h03b
`define AWDT_IDX_EVT_STATUS 10'h040
`define AWDT_IDX_EVT_CLEAR 10'h041
`define AWDT_IDX_EVT_ENABLE 10'h042
`define AWDT_IDX_LIVE 10'h043
`define AWDT_IDX_LAST_CH5 10'h044
`define AWDT_IDX_LAST_CH6 10'h045

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define AWDT_RST_HYST 8'hf0
`define AWDT_RST_UPPER 8'hff
`define AWDT_RST_ZERO 8'h00
`define AWDT_RST_EVT 4'h0

// ------------------------------------------------------------
// Field positions and widths
// ------------------------------------------------------------
`define AWDT_NIB_MSB 7
`define AWDT_NIB_LSB 4
`define AWDT_CFG_MSB 3
`define AWDT_CFG_LSB 0
`define AWDT_HYST_SHIFT 3
`define AWDT_CODE_W 12
`define AWDT_ADDR_W 12
`define AWDT_NUM_CFG 8
`define AWDT_NUM_DET 4

`endif

// ===== design/awdt_pkg.sv
`include "awdt_regs.svh"

package awdt_pkg;

    // ------------------------------------------------------------
    // Bus request carried from the APB master
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`AWDT_ADDR_W-1:0] paddr;
        logic pwrite;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } awdt_apb_req_t;

    // ------------------------------------------------------------
    // Conversion result from the converter
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic chan;
        logic [`AWDT_CODE_W-1:0] code;
    } awdt_sample_t;

    // ------------------------------------------------------------
    // Assembled window settings of one channel
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`AWDT_CODE_W-1:0] upper;
        logic [`AWDT_CODE_W-1:0] lower;
        logic [6:0] hyst;
        logic [3:0] debounce;
    } awdt_thresh_t;

    typedef enum logic [1:0] {
        AWDT_WATCH = 2'b01,
        AWDT_TRIPPED = 2'b10
    } awdt_det_state_t;

endpackage

// ===== design/awdt_top.sv
`timescale 1ns/1ps
`include "awdt_regs.svh"

// Overview of operation
// - The top byte of each high and low threshold is compared with result bits 11 to 4.
// - The high threshold's low nibble is bits 7-4 of the hysteresis register, set against result bits 3-0.
// - The low threshold's low nibble is bits 7-4 of the event-count register, set against result bits 3-0.
// - Hysteresis is the 4-bit field shifted left three places and applies to both thresholds.
// - An event flag is set only after n+1 consecutive qualifying samples, n being the count field.
// - After reset the upper byte reads all ones and the hysteresis register reads 0xF0.
// - After reset the lower byte and the nibble-plus-count register read zero.
module awdt_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire awdt_pkg::awdt_apb_req_t apb_req,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire awdt_pkg::awdt_sample_t sample,
    output logic [`AWDT_NUM_DET-1:0] event_flags,
    output logic irq
);
    import awdt_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] cfg_r [0:`AWDT_NUM_CFG-1];
    logic [`AWDT_NUM_DET-1:0] stat_r;
    logic [`AWDT_NUM_DET-1:0] en_r;
    logic [`AWDT_NUM_DET-1:0] det_fire;
    logic [`AWDT_NUM_DET-1:0] det_trip;
    logic [3:0] det_cnt [0:`AWDT_NUM_DET-1];
    logic [`AWDT_CODE_W-1:0] last_r [0:1];
    logic [31:0] prdata_r;
    logic [31:0] rd_nxt;
    logic pslverr_r;
    logic err_nxt;
    logic [9:0] idx;
    logic [9:0] cfg_off;
    logic aligned;
    logic setup_ph;
    logic wr_acc;
    logic hit_cfg;
    logic [2:0] cfg_sel;
    awdt_thresh_t th [0:1];

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign idx = apb_req.paddr[`AWDT_ADDR_W-1:2];
    assign aligned = (apb_req.paddr[1:0] == 2'b00);
    assign cfg_off = idx - `AWDT_IDX_CH5_HYST;
    assign hit_cfg = aligned && (idx >= `AWDT_IDX_CH5_HYST) && (idx <= `AWDT_IDX_CH6_LOWER);
    assign cfg_sel = cfg_off[2:0];
    assign setup_ph = psel & ~penable;
    assign wr_acc = psel & penable & apb_req.pwrite & apb_req.pstrb[0] & aligned;

    // ------------------------------------------------------------
    // Threshold registers
    // ------------------------------------------------------------
    for (genvar k = 0; k < `AWDT_NUM_CFG; k++) begin : g_cfg
        localparam logic [7:0] RST_VAL = ((k % 4) == 0) ? `AWDT_RST_HYST :
                                         ((k % 4) == 1) ? `AWDT_RST_UPPER :
                                         `AWDT_RST_ZERO;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cfg_r[k] <= RST_VAL;
            end else if (wr_acc && hit_cfg && (cfg_sel == 3'(k))) begin
                cfg_r[k] <= apb_req.pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Assemble per-channel window
    // ------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_th
        always_comb begin
            th[c].upper = {cfg_r[4*c+1], cfg_r[4*c][`AWDT_NIB_MSB:`AWDT_NIB_LSB]};
            th[c].lower = {cfg_r[4*c+3], cfg_r[4*c+2][`AWDT_NIB_MSB:`AWDT_NIB_LSB]};
            th[c].hyst = {cfg_r[4*c][`AWDT_CFG_MSB:`AWDT_CFG_LSB], 3'b000};
            th[c].debounce = cfg_r[4*c+2][`AWDT_CFG_MSB:`AWDT_CFG_LSB];
        end
    end

    // ------------------------------------------------------------
    // Last result per channel
    // ------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_last
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                last_r[c] <= 12'h000;
            end else if (sample.valid && (sample.chan == 1'(c))) begin
                last_r[c] <= sample.code;
            end
        end
    end

    // ------------------------------------------------------------
    // Window detectors: bit 2c is high side, bit 2c+1 is low side
    // ------------------------------------------------------------
    for (genvar g = 0; g < `AWDT_NUM_DET; g++) begin : g_det
        localparam int CH = g / 2;
        localparam bit IS_LOW = (g % 2) == 1;
        awdt_det_state_t st_r;
        logic [3:0] cnt_r;
        logic mine;
        logic qual;
        logic rel;
        logic [12:0] code_ext;
        logic [12:0] hyst_ext;
        logic [12:0] lim_ext;

        assign mine = sample.valid && (sample.chan == 1'(CH));
        assign code_ext = {1'b0, sample.code};
        assign hyst_ext = {6'h00, th[CH].hyst};
        assign lim_ext = IS_LOW ? {1'b0, th[CH].lower} : {1'b0, th[CH].upper};

        always_comb begin
            if (IS_LOW) begin
                qual = code_ext <= lim_ext;
                rel = code_ext > (lim_ext + hyst_ext);
            end else begin
                qual = code_ext >= lim_ext;
                rel = (code_ext + hyst_ext) < lim_ext;
            end
        end

        assign det_fire[g] = (st_r == AWDT_WATCH) && mine && qual &&
                             (cnt_r == th[CH].debounce);
        assign det_trip[g] = (st_r == AWDT_TRIPPED);
        assign det_cnt[g] = cnt_r;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                st_r <= AWDT_WATCH;
                cnt_r <= 4'h0;
            end else begin
                case (st_r)
                    AWDT_WATCH: begin
                        if (mine) begin
                            if (!qual) begin
                                cnt_r <= 4'h0;
                            end else if (cnt_r == th[CH].debounce) begin
                                st_r <= AWDT_TRIPPED;
                                cnt_r <= 4'h0;
                            end else begin
                                cnt_r <= cnt_r + 4'h1;
                            end
                        end
                    end
                    AWDT_TRIPPED: begin
                        if (mine && rel) begin
                            st_r <= AWDT_WATCH;
                            cnt_r <= 4'h0;
                        end
                    end
                    default: begin
                        st_r <= AWDT_WATCH;
                        cnt_r <= 4'h0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Event status, clear and enable
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= `AWDT_RST_EVT;
        end else if (wr_acc && (idx == `AWDT_IDX_EVT_CLEAR)) begin
            stat_r <= (stat_r & ~apb_req.pwdata[`AWDT_NUM_DET-1:0]) | det_fire;
        end else begin
            stat_r <= stat_r | det_fire;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= `AWDT_RST_EVT;
        end else if (wr_acc && (idx == `AWDT_IDX_EVT_ENABLE)) begin
            en_r <= apb_req.pwdata[`AWDT_NUM_DET-1:0];
        end
    end

    assign event_flags = stat_r;
    assign irq = |(stat_r & en_r);

    // ------------------------------------------------------------
    // Read mux, sampled in the setup phase
    // ------------------------------------------------------------
    always_comb begin
        rd_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        if (!aligned) begin
            err_nxt = 1'b1;
        end else if (hit_cfg) begin
            rd_nxt[7:0] = cfg_r[cfg_sel];
        end else begin
            case (idx)
                `AWDT_IDX_EVT_STATUS: begin
                    rd_nxt[`AWDT_NUM_DET-1:0] = stat_r;
                end
                `AWDT_IDX_EVT_CLEAR: begin
                    rd_nxt = 32'h0000_0000;
                end
                `AWDT_IDX_EVT_ENABLE: begin
                    rd_nxt[`AWDT_NUM_DET-1:0] = en_r;
                end
                `AWDT_IDX_LIVE: begin
                    rd_nxt[3:0] = det_trip;
                    rd_nxt[11:8] = det_cnt[0];
                    rd_nxt[15:12] = det_cnt[1];
                    rd_nxt[19:16] = det_cnt[2];
                    rd_nxt[23:20] = det_cnt[3];
                end
                `AWDT_IDX_LAST_CH5: begin
                    rd_nxt[`AWDT_CODE_W-1:0] = last_r[0];
                end
                `AWDT_IDX_LAST_CH6: begin
                    rd_nxt[`AWDT_CODE_W-1:0] = last_r[1];
                end
                default: begin
                    err_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r <= apb_req.pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr_r <= err_nxt;
        end
    end

    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r & psel & penable;

endmodule

// ===== verif/awdt_chk.sv
`timescale 1ns/1ps
`include "awdt_regs.svh"
// ----------------------------------------
// Port checker
// ----------------------------------------
module awdt_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire awdt_pkg::awdt_apb_req_t apb_req,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire awdt_pkg::awdt_sample_t sample,
    input wire logic [`AWDT_NUM_DET-1:0] event_flags,
    input wire logic irq
);
    import awdt_pkg::*;
    logic acc;
    logic wr_acc;
    logic clr_acc;
    assign acc = psel && penable;
    assign wr_acc = acc && apb_req.pwrite;
    assign clr_acc = wr_acc && apb_req.paddr[11:2] == `AWDT_IDX_EVT_CLEAR;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_gated: assert property (pslverr |-> acc) else $error("pslverr outside access");
    a_err_unaligned: assert property (acc && apb_req.paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access without error");
    a_err_zero: assert property (acc && !apb_req.pwrite && pslverr |-> prdata == 32'h0000_0000)
        else $error("refused read returns data");
    a_irq_quiet: assert property (event_flags == 4'h0 |-> !irq) else $error("irq without flag");
    a_irq_cause: assert property ($rose(irq) |-> $past(sample.valid) || $past(wr_acc))
        else $error("irq rose without cause");
    a_flag_cause: assert property (|(event_flags & ~$past(event_flags)) |-> $past(sample.valid))
        else $error("flag set without sample");
    a_flag_chan: assert property ($rose(event_flags[2]) |-> $past(sample.chan))
        else $error("second channel flag from first channel sample");
    a_flag_sticky: assert property (|($past(event_flags) & ~event_flags) |-> $past(clr_acc))
        else $error("flag dropped without clear");
    c_flag: cover property ($rose(event_flags[0]));
    c_low: cover property ($rose(event_flags[3]));
    c_err: cover property (pslverr);
    c_irq: cover property ($rose(irq));
endmodule

bind awdt_top awdt_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .apb_req(apb_req), .pready(pready), .prdata(prdata), .pslverr(pslverr), .sample(sample),
    .event_flags(event_flags), .irq(irq));

// ===== verif/awdt_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host bus master
// ----------------------------------------
module awdt_host (
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output awdt_pkg::awdt_apb_req_t apb_req
);
    import awdt_pkg::*;
    int timeouts = 0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        apb_req = '0;
    end
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
              output logic [31:0] r, output logic e);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        apb_req <= '{a, w, d, 4'h1};
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 100) timeouts++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        apb_req <= ~apb_req;
    endtask
endmodule

// ===== verif/test_analog_watchdog_thresholds_ch5_ch6.sv
`timescale 1ns/1ps
`include "awdt_regs.svh"
module test_analog_watchdog_thresholds_ch5_ch6;
    import awdt_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic psel, penable, pready, pslverr, irq;
    awdt_apb_req_t apb_req;
    awdt_sample_t sample = '0;
    logic [31:0] prdata;
    logic [3:0] event_flags;
    logic [3:0] flg = 0;
    logic [3:0] en = 0;
    int failures = 0;
    int num_checks = 0;
    int mem[8];
    int cnt[4] = '{0, 0, 0, 0};
    bit trip[4] = '{0, 0, 0, 0};
    int last[2] = '{0, 0};
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    awdt_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .apb_req(apb_req), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .sample(sample), .event_flags(event_flags), .irq(irq));
    awdt_host host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .apb_req(apb_req));
    // ----------------------------------------
    // Checks and bus tasks
    // ----------------------------------------
    task close_out;
        failures += host.timeouts;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task bus(input int idx, input logic w, input logic [7:0] d, output logic [31:0] r,
             output logic e);
        host.xfer(12'(idx * 4), w, {24'h0000_00, d}, r, e);
        if (host.timeouts > 0) close_out;
    endtask
    task rd(input int idx, input int exp, input logic xe);
        logic [31:0] r;
        logic e;
        bus(idx, 1'b0, 8'h00, r, e);
        chk(r, exp);
        chk(e, xe);
    endtask
    task wr(input int idx, input logic [7:0] v);
        logic [31:0] r;
        logic e;
        bus(idx, 1'b1, v, r, e);
        if (idx >= `AWDT_IDX_CH5_HYST && idx <= `AWDT_IDX_CH6_LOWER) mem[idx - 'h34] = v;
        if (idx == `AWDT_IDX_EVT_CLEAR) flg &= ~v[3:0];
        if (idx == `AWDT_IDX_EVT_ENABLE) en = v[3:0];
    endtask
    // ----------------------------------------
    // Sample driver and detector model
    // ----------------------------------------
    task smp(input int c, input int code);
        int up, lo, hy, d, q;
        up = mem[c*4+1] * 16 + mem[c*4] / 16;
        lo = mem[c*4+3] * 16 + mem[c*4+2] / 16;
        hy = (mem[c*4] % 16) * 8;
        @(posedge pclk);
        sample <= '{1'b1, c[0], code[11:0]};
        @(posedge pclk);
        sample.valid <= 1'b0;
        last[c] = code;
        for (int i = 0; i < 2; i++) begin
            d = c * 2 + i;
            q = i ? code <= lo : code >= up;
            if (trip[d]) begin
                if (i ? code > lo + hy : code < up - hy) trip[d] = 0;
            end else if (q) begin
                cnt[d]++;
                if (cnt[d] == mem[c*4+2] % 16 + 1) begin
                    flg[d] = 1;
                    trip[d] = 1;
                    cnt[d] = 0;
                end
            end else begin
                cnt[d] = 0;
            end
        end
        #1;
        chk(event_flags, flg);
        chk(irq, |(flg & en));
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int c, t, code;
        logic [7:0] v;
        logic [31:0] rr;
        logic ee;
        void'($urandom(32'he085_4d14));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            mem[i] = (i % 4 == 0) ? 'hf0 : (i % 4 == 1) ? 'hff : 0;
            rd(`AWDT_IDX_CH5_HYST + i, mem[i], 1'b0);
        end
        rd('h3ff, 0, 1'b1);
        host.xfer(12'h0d5, 1'b0, 32'h0000_0000, rr, ee);
        chk(rr, 32'h0000_0000);
        chk(ee, 1'b1);
        $display("test reset_values done");
        repeat (6) begin
            for (int i = 0; i < 8; i++) begin
                v = 8'($urandom);
                if (i % 4 == 2) v[3:2] = 2'h0;
                wr(`AWDT_IDX_CH5_HYST + i, v);
                rd(`AWDT_IDX_CH5_HYST + i, v, 1'b0);
            end
            wr(`AWDT_IDX_EVT_ENABLE, 8'($urandom));
            repeat (80) begin
                c = $urandom_range(0, 1);
                t = $urandom_range(0, 1) ? mem[c*4+1] * 16 + mem[c*4] / 16
                                         : mem[c*4+3] * 16 + mem[c*4+2] / 16;
                code = t + (($urandom % 4) ? $urandom_range(0, 4) - 2 : $urandom_range(0, 160) - 80);
                code = code < 0 ? 0 : code > 4095 ? 4095 : code;
                smp(c, code);
            end
            rd(`AWDT_IDX_LAST_CH5, last[0], 1'b0);
            rd(`AWDT_IDX_LAST_CH6, last[1], 1'b0);
            rd(`AWDT_IDX_EVT_STATUS, flg, 1'b0);
            wr(`AWDT_IDX_EVT_CLEAR, 8'h0f);
            rd(`AWDT_IDX_EVT_STATUS, flg, 1'b0);
            $display("test watch_round done");
        end
        close_out;
    end
endmodule
